// >>> rtl/sdu_core.v
// shift and divide unit: single shift, pair shift and signed divide
`timescale 1ns/1ps
`include "sdu_regs.vh"

module sdu_core (
    input wire CLK,
    input wire SYS_RST,
    input wire CE,
    input wire START,
    input wire [1:0] OPCODE,
    input wire [2:0] REG_SEL,
    input wire [15:0] SRC,
    input wire [15:0] REG_HI,
    input wire [15:0] REG_LO,
    output reg BUSY,
    output reg DONE,
    output reg WR_HI,
    output reg [2:0] HI_IDX,
    output reg [15:0] HI_DATA,
    output reg WR_LO,
    output reg [2:0] LO_IDX,
    output reg [15:0] LO_DATA,
    output reg FLAG_N,
    output reg FLAG_Z,
    output reg FLAG_V,
    output reg FLAG_C
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SHIFT = 4'h2;
    localparam [3:0] ST_DIV = 4'h4;
    localparam [3:0] ST_FIN = 4'h8;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [31:0] acc;
    reg [5:0] cnt;
    reg go_right;
    reg is_pair;
    reg is_rot;
    reg is_div;
    reg sv;
    reg sc;
    reg abort;
    reg zdiv;
    reg [2:0] sel;
    reg q_neg;
    reg r_neg;

    wire take = START & (state == ST_IDLE);
    wire [5:0] raw_cnt = SRC[`SDU_CNT_MSB:0];
    // two's complement of the field gives the right-shift distance; -32 maps to 6'h20
    wire [5:0] mag_cnt = raw_cnt[`SDU_CNT_MSB] ? (~raw_cnt + 6'h01) : raw_cnt;
    wire op_pair = (OPCODE == `SDU_OP_PAIR);
    wire op_div = (OPCODE == `SDU_OP_DIV);
    wire [31:0] dvd = {REG_HI, REG_LO};
    wire [15:0] dsr_mag = SRC[15] ? (~SRC + 16'h0001) : SRC;
    wire [31:0] dvd_mag = dvd[31] ? (~dvd + 32'h00000001) : dvd;
    wire div_start = take & op_div & (SRC != 16'h0000);
    wire div_done;
    wire [31:0] q_mag;
    wire [15:0] r_mag;

    sdu_div u_div (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .start(div_start),
        .dividend(dvd_mag),
        .divisor(dsr_mag),
        .done(div_done),
        .quotient(q_mag),
        .remainder(r_mag)
    );

    // quotient must fit a signed 16-bit word, one more step allowed when negative
    wire q_ovf = q_neg ? (q_mag > `SDU_QNEG_MAX) : (q_mag > `SDU_QPOS_MAX);
    wire [31:0] q_signed = q_neg ? (~q_mag + 32'h00000001) : q_mag;
    wire [15:0] r_signed = r_neg ? (~r_mag + 16'h0001) : r_mag;
    wire bottom = (is_pair & ~is_rot) ? acc[0] : acc[16];
    wire [15:0] res_hi = acc[31:16];
    wire res_zero = is_pair & ~is_rot ? (acc == 32'h00000000) : (res_hi == 16'h0000);

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (START) begin
                    if (op_div)
                        next_state = (SRC == 16'h0000) ? ST_FIN : ST_DIV;
                    else
                        next_state = (mag_cnt == `SDU_CNT_ZERO) ? ST_FIN : ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (cnt == 6'h01)
                    next_state = ST_FIN;
            end
            ST_DIV: begin
                if (div_done)
                    next_state = ST_FIN;
            end
            ST_FIN: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // operand capture and the shift datapath
    always @(posedge CLK) begin
        if (SYS_RST) begin
            state <= ST_IDLE;
            acc <= 32'h00000000;
            cnt <= `SDU_CNT_ZERO;
            go_right <= 1'b0;
            is_pair <= 1'b0;
            is_rot <= 1'b0;
            is_div <= 1'b0;
            sv <= 1'b0;
            sc <= 1'b0;
            zdiv <= 1'b0;
            sel <= `SDU_RST_IDX;
            q_neg <= 1'b0;
            r_neg <= 1'b0;
        end else if (CE) begin
            state <= next_state;
            if (take) begin
                // the single register sits in the upper half so bit 31 is its sign
                acc <= op_pair ? {REG_HI, REG_LO} : {REG_HI, 16'h0000};
                cnt <= mag_cnt;
                go_right <= raw_cnt[`SDU_CNT_MSB];
                is_pair <= op_pair;
                is_rot <= op_pair & REG_SEL[0] & raw_cnt[`SDU_CNT_MSB];
                is_div <= op_div;
                sv <= 1'b0;
                sc <= 1'b0;
                zdiv <= op_div & (SRC == 16'h0000);
                sel <= REG_SEL;
                q_neg <= dvd[31] ^ SRC[15];
                r_neg <= dvd[31];
            end else if (state == ST_SHIFT) begin
                cnt <= cnt - 6'h01;
                if (go_right) begin
                    sc <= bottom;
                    if (is_rot) begin
                        acc[31:16] <= {acc[16], acc[31:17]};
                        sv <= sv | (acc[16] ^ acc[31]);
                    end else begin
                        acc <= {acc[31], acc[31:1]};
                    end
                end else begin
                    sc <= acc[31];
                    acc <= {acc[30:0], 1'b0};
                    sv <= sv | (acc[31] ^ acc[30]);
                end
            end
        end
    end

    // results and flags are registered once at the finish state
    always @(posedge CLK) begin
        if (SYS_RST) begin
            BUSY <= 1'b0;
            DONE <= 1'b0;
            WR_HI <= 1'b0;
            WR_LO <= 1'b0;
            HI_IDX <= `SDU_RST_IDX;
            LO_IDX <= `SDU_RST_IDX;
            HI_DATA <= `SDU_RST_DATA;
            LO_DATA <= `SDU_RST_DATA;
            FLAG_N <= 1'b0;
            FLAG_Z <= 1'b0;
            FLAG_V <= 1'b0;
            FLAG_C <= 1'b0;
            abort <= 1'b0;
        end else if (CE) begin
            DONE <= 1'b0;
            WR_HI <= 1'b0;
            WR_LO <= 1'b0;
            if (take)
                BUSY <= 1'b1;
            if (state == ST_DIV && div_done)
                abort <= q_ovf;
            if (state == ST_FIN) begin
                BUSY <= 1'b0;
                DONE <= 1'b1;
                HI_IDX <= sel;
                LO_IDX <= sel | 3'h1;
                if (is_div) begin
                    FLAG_C <= zdiv;
                    if (zdiv | abort) begin
                        // aborted divide leaves both registers untouched
                        FLAG_V <= 1'b1;
                        FLAG_N <= 1'b0;
                        FLAG_Z <= 1'b0;
                    end else begin
                        WR_HI <= 1'b1;
                        WR_LO <= 1'b1;
                        HI_DATA <= q_signed[15:0];
                        LO_DATA <= r_signed;
                        FLAG_V <= 1'b0;
                        FLAG_N <= q_signed[15];
                        FLAG_Z <= (q_signed[15:0] == 16'h0000);
                    end
                end else begin
                    WR_HI <= 1'b1;
                    // an odd pair names one register, so only the upper half is stored
                    WR_LO <= is_pair & ~sel[0];
                    HI_DATA <= res_hi;
                    LO_DATA <= acc[15:0];
                    FLAG_N <= acc[31];
                    FLAG_Z <= res_zero;
                    FLAG_V <= sv;
                    FLAG_C <= sc;
                end
            end
        end
    end
endmodule

// >>> inc/sdu_regs.vh
// constants shared by the shift and divide unit
`ifndef SDU_REGS_VH
`define SDU_REGS_VH

// operation select codes
`define SDU_OP_SINGLE 2'h0
`define SDU_OP_PAIR 2'h1
`define SDU_OP_DIV 2'h2

// shift count field of the source operand
`define SDU_CNT_MSB 5
`define SDU_CNT_ZERO 6'h00

// division step count and quotient limits
`define SDU_DIV_STEPS 6'h20
`define SDU_QPOS_MAX 32'h00007FFF
`define SDU_QNEG_MAX 32'h00008000

// reset values
`define SDU_RST_DATA 16'h0000
`define SDU_RST_IDX 3'h0

`endif

// >>> rtl/sdu_div.v
// unsigned 32 by 16 restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
`include "sdu_regs.vh"

module sdu_div (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire start,
    input wire [31:0] dividend,
    input wire [15:0] divisor,
    output reg done,
    output wire [31:0] quotient,
    output wire [15:0] remainder
);
    reg [31:0] work;
    reg [15:0] rem;
    reg [15:0] dsr;
    reg [5:0] cnt;
    wire [16:0] trial = {rem, work[31]};
    wire fits = trial >= {1'b0, dsr};
    wire [16:0] diff = trial - {1'b0, dsr};

    assign quotient = work;
    assign remainder = rem;

    always @(posedge clk) begin
        if (rst) begin
            work <= 32'h00000000;
            rem <= `SDU_RST_DATA;
            dsr <= `SDU_RST_DATA;
            cnt <= `SDU_CNT_ZERO;
            done <= 1'b0;
        end else if (ce) begin
            if (start) begin
                work <= dividend;
                rem <= `SDU_RST_DATA;
                dsr <= divisor;
                cnt <= `SDU_DIV_STEPS;
                done <= 1'b0;
            end else if (cnt != `SDU_CNT_ZERO) begin
                // the quotient bit enters where the dividend bit left
                work <= {work[30:0], fits};
                rem <= fits ? diff[15:0] : trial[15:0];
                cnt <= cnt - 6'h01;
                done <= (cnt == 6'h01);
            end else begin
                done <= 1'b0;
            end
        end
    end
endmodule

// >>> tb/sdu_asserts.sv
// port checker for the shift and divide unit
`timescale 1ns/1ps
module sdu_asserts (
    input wire CLK,
    input wire SYS_RST,
    input wire CE,
    input wire START,
    input wire [1:0] OPCODE,
    input wire [15:0] SRC,
    input wire BUSY,
    input wire DONE,
    input wire WR_HI,
    input wire WR_LO,
    input wire [2:0] HI_IDX,
    input wire [2:0] LO_IDX,
    input wire [15:0] HI_DATA,
    input wire [15:0] LO_DATA,
    input wire FLAG_N,
    input wire FLAG_Z,
    input wire FLAG_V,
    input wire FLAG_C
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire take = CE && START && !BUSY;
    wire [5:0] mag = SRC[5] ? 6'h00 - SRC[5:0] : SRC[5:0];
    wire [3:0] flg = {FLAG_N, FLAG_Z, FLAG_V, FLAG_C};
    reg [5:0] cnt;
    reg [5:0] lat;
    reg [1:0] op;
    // expected length of the operation, latched at the take edge
    always @(posedge CLK) begin
        if (take) begin
            cnt <= 6'h00;
            op <= OPCODE;
            // divide takes 32 divider steps plus one cycle to judge the quotient
            lat <= (OPCODE != 2'h2) ? mag : ((SRC == 16'h0000) ? 6'h00 : 6'h21);
        end else if (BUSY && CE) begin
            cnt <= cnt + 6'h01;
        end
    end
    sequence s_take;
        take;
    endsequence
    sequence s_end;
        DONE ##1 !DONE && !WR_HI && !WR_LO;
    endsequence
    a_done_time: assert property (DONE |-> cnt == lat + 6'h01) else $error("done late");
    a_busy_take: assert property (s_take |=> BUSY) else $error("busy missing");
    a_done_pulse: assert property (DONE |-> s_end) else $error("done not a pulse");
    a_sh_flags: assert property (DONE && WR_HI && op != 2'h1 |-> FLAG_N == HI_DATA[15]
        && FLAG_Z == (HI_DATA == 16'h0000)) else $error("n z wrong");
    a_pair_flags: assert property (DONE && op == 2'h1 && WR_LO |-> FLAG_N == HI_DATA[15]
        && FLAG_Z == ({HI_DATA, LO_DATA} == 32'h0)) else $error("pair n z wrong");
    a_pair_wr: assert property (DONE && op == 2'h1 |-> WR_HI && LO_IDX == (HI_IDX | 3'h1)
        && WR_LO == !HI_IDX[0]) else $error("pair write wrong");
    a_div_zero: assert property (DONE && op == 2'h2 && lat == 6'h00 |-> FLAG_V && FLAG_C
        && !WR_HI && !WR_LO) else $error("zero divide wrong");
    a_div_carry: assert property (DONE && op == 2'h2 && lat != 6'h00 |-> !FLAG_C)
        else $error("divide carry set");
    a_div_abort: assert property (DONE && op == 2'h2 && FLAG_V |-> !WR_HI && !WR_LO)
        else $error("abort wrote");
    a_flag_hold: assert property (!$past(SYS_RST) && $changed(flg) |-> DONE)
        else $error("flags moved");
endmodule
bind sdu_core sdu_asserts i_chk (.CLK, .SYS_RST, .CE, .START, .OPCODE, .SRC, .BUSY,
    .DONE, .WR_HI, .WR_LO, .HI_IDX, .LO_IDX, .HI_DATA, .LO_DATA, .FLAG_N, .FLAG_Z,
    .FLAG_V, .FLAG_C);

// >>> tb/sdu_regfile.sv
// register file of the issuing processor, feeding and absorbing operands
`timescale 1ns/1ps
module sdu_regfile (
    input wire clk,
    input wire ld,
    input wire [2:0] ld_idx,
    input wire [15:0] ld_data,
    input wire [2:0] sel,
    input wire wr_hi,
    input wire [2:0] hi_idx,
    input wire [15:0] hi_data,
    input wire wr_lo,
    input wire [2:0] lo_idx,
    input wire [15:0] lo_data,
    output wire [15:0] reg_hi,
    output wire [15:0] reg_lo
);
    reg [15:0] gpr [0:7];
    assign reg_hi = gpr[sel];
    assign reg_lo = gpr[sel | 3'h1];
    // later writes win, so a result lands over a preload in the same cycle
    always @(posedge clk) begin
        if (ld) gpr[ld_idx] <= ld_data;
        if (wr_hi) gpr[hi_idx] <= hi_data;
        if (wr_lo) gpr[lo_idx] <= lo_data;
    end
endmodule

// >>> tb/sdu_core_bench.sv
// self-checking bench for the shift and divide unit
`timescale 1ns/1ps
module sdu_core_bench;
    reg CLK = 1'b0;
    reg SYS_RST = 1'b1;
    reg CE = 1'b1;
    reg START = 1'b0;
    reg [1:0] OPCODE = 2'h0;
    reg [2:0] REG_SEL = 3'h0;
    reg [15:0] SRC = 16'h0000;
    reg ld = 1'b0;
    reg [2:0] ld_idx = 3'h0;
    reg [15:0] ld_data = 16'h0000;
    wire [15:0] REG_HI, REG_LO, HI_DATA, LO_DATA;
    wire [2:0] HI_IDX, LO_IDX;
    wire BUSY, DONE, WR_HI, WR_LO, FLAG_N, FLAG_Z, FLAG_V, FLAG_C;
    integer err_count = 0;
    integer checked = 0;
    always #2 CLK = ~CLK;
    sdu_core i_dut (.CLK, .SYS_RST, .CE, .START, .OPCODE, .REG_SEL, .SRC, .REG_HI,
        .REG_LO, .BUSY, .DONE, .WR_HI, .HI_IDX, .HI_DATA, .WR_LO, .LO_IDX, .LO_DATA,
        .FLAG_N, .FLAG_Z, .FLAG_V, .FLAG_C);
    sdu_regfile i_rf (.clk(CLK), .ld, .ld_idx, .ld_data, .sel(REG_SEL), .wr_hi(WR_HI),
        .hi_idx(HI_IDX), .hi_data(HI_DATA), .wr_lo(WR_LO), .lo_idx(LO_IDX),
        .lo_data(LO_DATA), .reg_hi(REG_HI), .reg_lo(REG_LO));
    task complete_run;
        begin
            if (err_count == 0 && checked > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t saw %h wanted %h", $time, seen, exp);
            end
        end
    endtask
    task res(input [15:0] hi, input [3:0] f);
        begin
            check(HI_DATA, hi);
            check({12'h000, FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, {12'h000, f});
        end
    endtask
    // preload sel and sel|1, issue one request, return with the done pulse visible
    task run(input [1:0] op, input [2:0] sel, input [15:0] src, a, b);
        integer n;
        begin
            @(posedge CLK) begin ld <= 1'b1; ld_idx <= sel | 3'h1; ld_data <= b; end
            @(posedge CLK) begin ld_idx <= sel; ld_data <= a; end
            @(posedge CLK) begin ld <= 1'b0; START <= 1'b1; OPCODE <= op; end
            REG_SEL <= sel;
            SRC <= src;
            @(posedge CLK) START <= 1'b0;
            #1;
            n = 0;
            while (DONE !== 1'b1 && n < 40) begin
                @(posedge CLK);
                #1;
                n = n + 1;
            end
            check({15'h0000, DONE}, 16'h0001);
        end
    endtask
    task t_single;
        begin
            run(2'h0, 3'h2, 16'h0002, 16'h4001, 16'h0000);
            res(16'h0004, 4'h3);
            run(2'h0, 3'h5, 16'h003F, 16'h8001, 16'h0000);
            res(16'hC000, 4'h9);
            run(2'h0, 3'h1, 16'h0020, 16'h8000, 16'h0000);
            res(16'hFFFF, 4'h9);
            run(2'h0, 3'h4, 16'h001F, 16'h0001, 16'h0000);
            res(16'h0000, 4'h6);
            run(2'h3, 3'h0, 16'h0040, 16'h0000, 16'h0000);
            res(16'h0000, 4'h4);
        end
    endtask
    task t_pair;
        begin
            run(2'h1, 3'h0, 16'h0001, 16'h4000, 16'h8001);
            res(16'h8001, 4'hA);
            check(LO_DATA, 16'h0002);
            run(2'h1, 3'h6, 16'h003F, 16'h0000, 16'h0003);
            res(16'h0000, 4'h1);
            check(LO_DATA, 16'h0001);
            run(2'h1, 3'h3, 16'h003F, 16'h0001, 16'h0001);
            res(16'h8000, 4'hB);
            check({15'h0000, WR_LO}, 16'h0000);
        end
    endtask
    task t_div;
        begin
            run(2'h2, 3'h2, 16'h0002, 16'hFFFF, 16'hFFF9);
            res(16'hFFFD, 4'h8);
            check(LO_DATA, 16'hFFFF);
            check({13'h0000, LO_IDX}, 16'h0003);
            run(2'h2, 3'h4, 16'hFFFE, 16'h0000, 16'h0007);
            res(16'hFFFD, 4'h8);
            check(LO_DATA, 16'h0001);
            run(2'h2, 3'h6, 16'h0002, 16'h0000, 16'h0001);
            res(16'h0000, 4'h4);
            run(2'h2, 3'h0, 16'h0000, 16'h0000, 16'h0005);
            check({12'h000, FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 16'h0003);
            check({14'h0000, WR_HI, WR_LO}, 16'h0000);
            run(2'h2, 3'h2, 16'h0001, 16'h0001, 16'h0000);
            check({12'h000, FLAG_N, FLAG_Z, FLAG_V, FLAG_C}, 16'h0002);
            check({14'h0000, WR_HI, WR_LO}, 16'h0000);
        end
    endtask
    // a held clock enable must stall the shift with busy up and no result
    task t_freeze;
        begin
            @(posedge CLK) begin ld <= 1'b1; ld_idx <= 3'h4; ld_data <= 16'h0003; end
            @(posedge CLK) begin ld <= 1'b0; START <= 1'b1; OPCODE <= 2'h0; end
            REG_SEL <= 3'h4;
            SRC <= 16'h0001;
            @(posedge CLK) begin START <= 1'b0; CE <= 1'b0; end
            repeat (6) @(posedge CLK);
            #1;
            check({14'h0000, BUSY, DONE}, 16'h0002);
            @(posedge CLK) CE <= 1'b1;
            repeat (2) @(posedge CLK);
            #1;
            check({14'h0000, BUSY, DONE}, 16'h0001);
            check({13'h0000, HI_IDX}, 16'h0004);
            res(16'h0006, 4'h0);
        end
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_single;
        t_pair;
        t_div;
        t_freeze;
        complete_run;
    end
    initial begin
        #10000;
        err_count = err_count + 1;
        complete_run;
    end
endmodule
